// [rtl/led_pwm_pkg.sv]
// Constants, register map and carrier types of the LED PWM and fault monitor
package led_pwm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int unsigned CLK_FREQ_HZ    = 250_000_000;
	localparam int unsigned CLK_PERIOD_NS  = 4;
	localparam int unsigned PWM_STEPS      = 256;
	localparam int unsigned IND_PWM_HZ     = 97_000;
	localparam int unsigned GRP_DIM_HZ     = 190;
	localparam int unsigned BLINK_FAST_HZ  = 24;
	localparam int unsigned SPIKE_NS       = 50;
	// Cycles per PWM step, rounded down so the rate is never below target
	localparam int unsigned IND_STEP_CYC        = CLK_FREQ_HZ / (IND_PWM_HZ * PWM_STEPS);
	localparam int unsigned GRP_DIM_STEP_CYC    = CLK_FREQ_HZ / (GRP_DIM_HZ * PWM_STEPS);
	localparam int unsigned BLINK_BASE_STEP_CYC = CLK_FREQ_HZ / (BLINK_FAST_HZ * PWM_STEPS);
	// Spike suppression, a least time so rounded up
	localparam int unsigned SPIKE_FILT_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] PWM_BASE_ADDR    = 8'h00;
	localparam logic [7:0] GRP_DUTY_ADDR    = 8'h10;
	localparam logic [7:0] GRP_FREQ_ADDR    = 8'h11;
	localparam logic [7:0] MODE_CTRL2_ADDR  = 8'h12;
	localparam logic [7:0] LED_MODE0_ADDR   = 8'h14;
	localparam logic [7:0] LED_MODE3_ADDR   = 8'h17;
	localparam logic [7:0] ERR_LOW_ADDR     = 8'h1D;
	localparam logic [7:0] ERR_HIGH_ADDR    = 8'h1E;

	// Field positions in mode_control_two
	localparam int unsigned MODE_CONTROL_TWO_CLR_OT_BIT = 7;
	localparam int unsigned MODE_CONTROL_TWO_BLINK_BIT  = 5;

	// Reset values
	localparam logic [7:0] PWM_RST      = 8'h00;
	localparam logic [7:0] GRP_DUTY_RST = 8'hFF;
	localparam logic [7:0] GRP_FREQ_RST = 8'h00;
	localparam logic [7:0] MODE_CONTROL_TWO_RST    = 8'h00;
	localparam logic [7:0] LED_MODE_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {LED_OFF, LED_ON, LED_IND, LED_GRP} led_mode_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_type;

	typedef struct packed {
		logic        ot_global;
		logic [15:0] ot_chan;
		logic [15:0] open_load;
	} fault_in_type;

endpackage

// [rtl/led_pwm_fault_monitor.sv]
// LED sink PWM, group dimming or blinking, and fault supervision for 16 channels
//
// Notes on behaviour
// - Each channel has an 8-bit PWM near 97 kHz, duty 0 to 255/256.
// - One shared 256-step group PWM: 190 Hz dim, or blink 24 Hz to 10.67 s.
// - Group PWM gates each channel in group mode on top of its own brightness PWM.
// - Open load flagged when sink current stays under the half-target threshold.
// - Channel error bits are read back through the two error flag registers.
// - Open load is judged only when the channel is fully on, no PWM.
// - Error bit is 1 on and normal, 0 on with open load, 0 off.
// - One global and sixteen channel temperature sensors feed the fault logic.
// - Global overtemperature turns all channels off and latches every error bit.
// - Shut channels restart by themselves once cool, if still switched on.
// - Latched overtemperature error stays until software clears it.
// - Channel overtemperature turns off and flags only that channel.
// - Channel temperature sensor is heeded only while that channel is on.
// - Open load or overtemperature alone marks the channel bit as erroneous.
// - Bit 7 of mode_control_two set to 1 clears latched overtemperature errors.
// - Serial clock and data inputs ignore spikes shorter than 50 ns.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps

module led_pwm_fault_monitor
	import led_pwm_pkg::*;
#(
	parameter int unsigned DIM_STEP_CYC   = GRP_DIM_STEP_CYC,
	parameter int unsigned BLINK_STEP_CYC = BLINK_BASE_STEP_CYC
)(
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	input  wire bus_req_type  bus_req,
	output logic [7:0]        rd_data_q,
	input  wire fault_in_type fault_in,
	input  wire logic [1:0]   serial_in,
	output logic [1:0]        serial_filt_q,
	output logic [15:0]       led_drive_q,
	output logic [15:0]       error_flags_q
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0]  pwm_q [0:15];
	logic [7:0]  grp_duty_q;
	logic [7:0]  grp_freq_q;
	logic [7:0]  mode_control_two_q;
	logic [31:0] led_mode_q;
	logic [15:0] ot_latch_q;
	logic [15:0] ot_latch_d;
	logic [3:0]  ind_pre_q;
	logic [7:0]  ind_cnt_q;
	logic [31:0] grp_pre_q;
	logic [31:0] grp_lim;
	logic [7:0]  grp_cnt_q;
	logic        grp_on;
	logic        clr_ot;
	logic [7:0]  rd_data_d;
	logic [1:0]  led_mode_idx;
	logic [3:0]  filt_cnt_q [0:1];

	// One clock domain for every check in this module, generate blocks included
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	assign clr_ot       = mode_control_two_q[MODE_CONTROL_TWO_CLR_OT_BIT];
	assign led_mode_idx = 2'(bus_req.addr - LED_MODE0_ADDR);

	////////////////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int k = 0; k < 16; k++) begin
				pwm_q[k] <= PWM_RST;
			end
			grp_duty_q <= GRP_DUTY_RST;
			grp_freq_q <= GRP_FREQ_RST;
			mode_control_two_q    <= MODE_CONTROL_TWO_RST;
			led_mode_q <= {4{LED_MODE_RST}};
		end else if (bus_req.wr) begin
			if (bus_req.addr[7:4] == PWM_BASE_ADDR[7:4]) begin
				pwm_q[bus_req.addr[3:0]] <= bus_req.wdata;
			end else if (bus_req.addr == GRP_DUTY_ADDR) begin
				grp_duty_q <= bus_req.wdata;
			end else if (bus_req.addr == GRP_FREQ_ADDR) begin
				grp_freq_q <= bus_req.wdata;
			end else if (bus_req.addr == MODE_CTRL2_ADDR) begin
				mode_control_two_q <= bus_req.wdata;
			end else if (bus_req.addr >= LED_MODE0_ADDR && bus_req.addr <= LED_MODE3_ADDR) begin
				led_mode_q[8*led_mode_idx +: 8] <= bus_req.wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read decode, data valid the cycle after the strobe
	always_comb begin
		rd_data_d = 8'h00;
		if (bus_req.addr[7:4] == PWM_BASE_ADDR[7:4]) begin
			rd_data_d = pwm_q[bus_req.addr[3:0]];
		end else if (bus_req.addr == GRP_DUTY_ADDR) begin
			rd_data_d = grp_duty_q;
		end else if (bus_req.addr == GRP_FREQ_ADDR) begin
			rd_data_d = grp_freq_q;
		end else if (bus_req.addr == MODE_CTRL2_ADDR) begin
			rd_data_d = mode_control_two_q;
		end else if (bus_req.addr >= LED_MODE0_ADDR && bus_req.addr <= LED_MODE3_ADDR) begin
			rd_data_d = led_mode_q[8*led_mode_idx +: 8];
		end else if (bus_req.addr == ERR_LOW_ADDR) begin
			rd_data_d = error_flags_q[7:0];
		end else if (bus_req.addr == ERR_HIGH_ADDR) begin
			rd_data_d = error_flags_q[15:8];
		end
	end

	// Read data register, holds zero outside a read answer
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_q <= 8'h00;
		end else if (bus_req.rd) begin
			rd_data_q <= rd_data_d;
		end else begin
			rd_data_q <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Individual PWM time base, one step every IND_STEP_CYC cycles
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ind_pre_q <= 4'h0;
			ind_cnt_q <= 8'h00;
		end else if (ind_pre_q == 4'(IND_STEP_CYC - 1)) begin
			ind_pre_q <= 4'h0;
			ind_cnt_q <= ind_cnt_q + 8'h01;
		end else begin
			ind_pre_q <= ind_pre_q + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Group PWM time base, step length fixed for dimming or scaled for blinking
	always_comb begin
		if (mode_control_two_q[MODE_CONTROL_TWO_BLINK_BIT]) begin
			grp_lim = 32'(({24'h000000, grp_freq_q} + 32'h00000001) * BLINK_STEP_CYC);
		end else begin
			grp_lim = 32'(DIM_STEP_CYC);
		end
	end

	// Compare with >= so a shrinking period never runs away
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			grp_pre_q <= 32'h00000000;
			grp_cnt_q <= 8'h00;
		end else if (grp_pre_q >= grp_lim - 32'h00000001) begin
			grp_pre_q <= 32'h00000000;
			grp_cnt_q <= grp_cnt_q + 8'h01;
		end else begin
			grp_pre_q <= grp_pre_q + 32'h00000001;
		end
	end

	assign grp_on = grp_cnt_q < grp_duty_q;

	////////////////////////////////////////////////////////////////////////////
	// Per-channel drive, fault latching and error status
	for (genvar i = 0; i < 16; i++) begin : g_chan
		led_mode_type mode;
		logic         ind_on;
		logic         want;
		logic         ot_set;
		logic         ol_err;

		assign mode   = led_mode_type'(led_mode_q[2*i +: 2]);
		assign ind_on = ind_cnt_q < pwm_q[i];
		// Group gate on top of the channel PWM
		assign want = (mode == LED_ON) || (mode == LED_IND && ind_on) ||
			(mode == LED_GRP && ind_on && grp_on);
		// Channel sensor counts only while the channel is switched on
		assign ot_set = fault_in.ot_global ||
			(fault_in.ot_chan[i] && mode != LED_OFF);
		// Open load judged only in full-on mode
		assign ol_err = (mode == LED_ON) && fault_in.open_load[i];
		// Clear bit held high keeps the latch empty
		assign ot_latch_d[i] = clr_ot ? 1'b0 : (ot_latch_q[i] || ot_set);

		// Live shutdown, drive returns by itself once cool
		always_ff @(posedge ref_clk or negedge rst_b) begin
			if (!rst_b) begin
				led_drive_q[i] <= 1'b0;
			end else begin
				led_drive_q[i] <= want && !fault_in.ot_global && !fault_in.ot_chan[i];
			end
		end

		// Sticky overtemperature status
		always_ff @(posedge ref_clk or negedge rst_b) begin
			if (!rst_b) begin
				ot_latch_q[i] <= 1'b0;
			end else begin
				ot_latch_q[i] <= ot_latch_d[i];
			end
		end

		// Status bit: 1 means on and healthy
		always_ff @(posedge ref_clk or negedge rst_b) begin
			if (!rst_b) begin
				error_flags_q[i] <= 1'b0;
			end else begin
				error_flags_q[i] <= (mode != LED_OFF) && !ol_err && !ot_latch_d[i];
			end
		end

		chan_shut_a: assert property (fault_in.ot_chan[i] |=> !led_drive_q[i])
			else $error("channel kept driving while hot");
		err_off_a: assert property (mode == LED_OFF |=> !error_flags_q[i])
			else $error("off channel reads healthy");
		open_load_a: assert property (mode == LED_ON && fault_in.open_load[i]
			|=> !error_flags_q[i])
			else $error("open load not flagged");
		pwm_no_ol_a: assert property (mode == LED_IND && !ot_latch_q[i] && !clr_ot
			&& !fault_in.ot_global && !fault_in.ot_chan[i] |=> error_flags_q[i])
			else $error("open load judged during PWM");
		restart_a: assert property (mode == LED_ON && !fault_in.ot_global
			&& !fault_in.ot_chan[i] |=> led_drive_q[i])
			else $error("channel did not restart");
		ot_sticky_a: assert property (ot_latch_q[i] && !clr_ot |=> ot_latch_q[i]
			##0 !error_flags_q[i])
			else $error("overtemperature error lost");
		duty_zero_a: assert property (mode != LED_ON && pwm_q[i] == 8'h00
			|=> !led_drive_q[i])
			else $error("zero duty drove the channel");
		grp_gate_a: assert property (mode == LED_GRP && !grp_on
			|=> !led_drive_q[i])
			else $error("group gate ignored");

		// Healthy full-on channel must read 1
		healthy_on_a: assert property (mode == LED_ON && !fault_in.open_load[i]
			&& !ot_latch_q[i] && !clr_ot && !fault_in.ot_global
			&& !fault_in.ot_chan[i] |=> error_flags_q[i])
			else $error("healthy channel flagged");
		// Off channel ignores its own sensor for latching
		off_no_latch_a: assert property (mode == LED_OFF && !fault_in.ot_global
			&& !ot_latch_q[i] |=> !ot_latch_q[i])
			else $error("off channel latched overtemperature");
	end

	////////////////////////////////////////////////////////////////////////////
	// Spike filter on serial clock (bit 0) and data (bit 1)
	for (genvar j = 0; j < 2; j++) begin : g_filt
		// Output follows only after SPIKE_FILT_CYC cycles of steady difference
		always_ff @(posedge ref_clk or negedge rst_b) begin
			if (!rst_b) begin
				filt_cnt_q[j]    <= 4'h0;
				serial_filt_q[j] <= 1'b1;
			end else if (serial_in[j] == serial_filt_q[j]) begin
				filt_cnt_q[j] <= 4'h0;
			end else if (filt_cnt_q[j] == 4'(SPIKE_FILT_CYC - 1)) begin
				filt_cnt_q[j]    <= 4'h0;
				serial_filt_q[j] <= serial_in[j];
			end else begin
				filt_cnt_q[j] <= filt_cnt_q[j] + 4'h1;
			end
		end

		filt_rise_a: assert property ($rose(serial_filt_q[j]) |->
			$past(serial_in[j], 1) && $past(serial_in[j], 13))
			else $error("spike passed the filter");
		filt_fall_a: assert property ($fell(serial_filt_q[j]) |->
			!$past(serial_in[j], 1) && !$past(serial_in[j], 13))
			else $error("spike passed the filter");
		// Agreeing input keeps the difference counter empty
		filt_idle_a: assert property (serial_in[j] == serial_filt_q[j]
			|=> filt_cnt_q[j] == 4'h0)
			else $error("filter counter ran on steady input");
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks across channels and on the register port
	glob_shut_a: assert property (fault_in.ot_global |=> led_drive_q == 16'h0000
		&& (error_flags_q == 16'h0000 || $past(clr_ot)))
		else $error("global overtemperature did not shut all");
	rd_idle_a: assert property (!bus_req.rd |=> rd_data_q == 8'h00)
		else $error("read data outside a read answer");
	ind_step_a: assert property ($changed(ind_cnt_q)
		|-> $past(ind_pre_q) == 4'(IND_STEP_CYC - 1))
		else $error("brightness step came early");
	ot_clear_a: assert property (clr_ot |=> ot_latch_q == 16'h0000)
		else $error("clear bit left errors latched");
	read_low_a: assert property (bus_req.rd && bus_req.addr == ERR_LOW_ADDR
		|=> rd_data_q == $past(error_flags_q[7:0]))
		else $error("error_flags_low read wrong");
	read_high_a: assert property (bus_req.rd && bus_req.addr == ERR_HIGH_ADDR
		|=> rd_data_q == $past(error_flags_q[15:8]))
		else $error("error_flags_high read wrong");
	blink_step_a: assert property (mode_control_two_q[MODE_CONTROL_TWO_BLINK_BIT] && $changed(grp_cnt_q)
		|-> $past(grp_pre_q) >= $past(grp_lim) - 32'h00000001)
		else $error("group step came early");

	global_trip_c: cover property (fault_in.ot_global ##1 led_drive_q == 16'h0000);
	clear_c:       cover property (ot_latch_q != 16'h0000 ##1 clr_ot ##1 !clr_ot);
	blink_c:       cover property (mode_control_two_q[MODE_CONTROL_TWO_BLINK_BIT] && $changed(grp_cnt_q));
	spike_c:       cover property ($changed(serial_in[0]) ##1 $changed(serial_in[0]));
	open_load_c:   cover property (fault_in.open_load[3] ##1 error_flags_q[3] == 1'b0);

endmodule

// [verif/led_load_model.sv]
// LED string and die temperature model seen by the sink outputs
`timescale 1ns/1ps

module led_load_model
	import led_pwm_pkg::*;
(
	input  wire logic [15:0] led_drive,
	input  wire logic [15:0] connected,
	input  wire logic        hot_global,
	input  wire logic [15:0] hot_chan,
	output fault_in_type     fault_in
);
	// No current when the sink is off or the string is broken
	assign fault_in.open_load = ~(led_drive & connected);
	// One die sensor plus one sensor per channel
	assign fault_in.ot_global = hot_global;
	assign fault_in.ot_chan   = hot_chan;
endmodule

// [verif/test_led_pwm_fault_monitor.sv]
// Self-checking bench for the LED PWM and fault monitor
`timescale 1ns/1ps

module test_led_pwm_fault_monitor
	import led_pwm_pkg::*;
;
	logic         ref_clk;
	logic         rst_b;
	bus_req_type  bus_req;
	logic [7:0]   rd_data;
	fault_in_type fault_in;
	logic [1:0]   serial_in;
	logic [1:0]   serial_filt;
	logic [15:0]  led_drive;
	logic [15:0]  error_flags;
	logic [15:0]  connected;
	logic [15:0]  hot_chan;
	logic         hot_global;
	logic [7:0]   d;
	int           mismatches;
	int           samples_checked;

	led_pwm_fault_monitor #(.DIM_STEP_CYC(4), .BLINK_STEP_CYC(2)) i_dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data_q(rd_data),
		.fault_in(fault_in), .serial_in(serial_in), .serial_filt_q(serial_filt),
		.led_drive_q(led_drive), .error_flags_q(error_flags));

	led_load_model i_load (.led_drive(led_drive), .connected(connected),
		.hot_global(hot_global), .hot_chan(hot_chan), .fault_in(fault_in));

	////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] expected);
		samples_checked++;
		if (seen !== expected) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
		#1 v = rd_data;
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic reset_values();
		check(led_drive, 16'h0000);
		check(error_flags, 16'h0000);
		check({14'h0000, serial_filt}, 16'h0003);
		rd(GRP_DUTY_ADDR, d);
		check({8'h00, d}, {8'h00, GRP_DUTY_RST});
		cycles(1);
		check({8'h00, rd_data}, 16'h0000);
		rd(MODE_CTRL2_ADDR, d);
		check({8'h00, d}, {8'h00, MODE_CONTROL_TWO_RST});
		rd(8'hF0, d);
		check({8'h00, d}, 16'h0000);
	endtask

	task automatic open_load_scn();
		for (int r = 0; r < 4; r++) begin
			wr(LED_MODE0_ADDR + 8'(r), 8'h55);
		end
		cycles(3);
		check(led_drive, 16'hFFFF);
		check(error_flags, 16'hFFFF);
		@(posedge ref_clk);
		connected <= 16'hFFF7;
		cycles(3);
		check(error_flags, 16'hFFF7);
		wr(ERR_LOW_ADDR, 8'hFF);
		rd(ERR_LOW_ADDR, d);
		check({8'h00, d}, 16'h00F7);
		rd(ERR_HIGH_ADDR, d);
		check({8'h00, d}, 16'h00FF);
		// Channel 3 into its own PWM mode: no open-load verdict
		wr(LED_MODE0_ADDR, 8'h95);
		cycles(3);
		check(error_flags, 16'hFFFF);
		// Channel 3 off with a healthy string still reads 0
		wr(LED_MODE0_ADDR, 8'h15);
		@(posedge ref_clk);
		connected <= 16'hFFFF;
		cycles(3);
		check(led_drive, 16'hFFF7);
		check(error_flags, 16'hFFF7);
		wr(LED_MODE0_ADDR, 8'h55);
	endtask

	task automatic global_ot_scn();
		@(posedge ref_clk);
		hot_global <= 1'b1;
		cycles(3);
		check(led_drive, 16'h0000);
		check(error_flags, 16'h0000);
		@(posedge ref_clk);
		hot_global <= 1'b0;
		cycles(3);
		check(led_drive, 16'hFFFF);
		check(error_flags, 16'h0000);
		rd(ERR_HIGH_ADDR, d);
		check({8'h00, d}, 16'h0000);
		wr(MODE_CTRL2_ADDR, 8'h80);
		wr(MODE_CTRL2_ADDR, 8'h00);
		cycles(2);
		check(error_flags, 16'hFFFF);
	endtask

	task automatic chan_ot_scn();
		@(posedge ref_clk);
		hot_chan <= 16'h0200;
		cycles(3);
		check(led_drive, 16'hFDFF);
		check(error_flags, 16'hFDFF);
		@(posedge ref_clk);
		hot_chan <= 16'h0000;
		cycles(3);
		check(led_drive, 16'hFFFF);
		check(error_flags, 16'hFDFF);
		// Channel 10 off while its sensor trips
		wr(LED_MODE0_ADDR + 8'h02, 8'h45);
		@(posedge ref_clk);
		hot_chan <= 16'h0400;
		cycles(3);
		@(posedge ref_clk);
		hot_chan <= 16'h0000;
		wr(LED_MODE0_ADDR + 8'h02, 8'h55);
		cycles(3);
		check(error_flags, 16'hFDFF);
		wr(MODE_CTRL2_ADDR, 8'h80);
		wr(MODE_CTRL2_ADDR, 8'h00);
		cycles(2);
		check(error_flags, 16'hFFFF);
	endtask

	// Channel 0 own PWM, channel 1 own PWM gated by a zero group duty
	task automatic pwm_scn();
		logic [7:0]  duty[3]  = '{8'h00, 8'h80, 8'hFF};
		logic [15:0] highs[3] = '{16'd0, 16'd1280, 16'd2550};
		int n0;
		int n1;
		wr(PWM_BASE_ADDR + 8'h01, 8'h80);
		wr(GRP_DUTY_ADDR, 8'h00);
		wr(LED_MODE0_ADDR, 8'h5E);
		for (int i = 0; i < 3; i++) begin
			wr(PWM_BASE_ADDR, duty[i]);
			if (i == 2) begin
				wr(MODE_CTRL2_ADDR, 8'h20);
			end
			cycles(2);
			n0 = 0;
			n1 = 0;
			repeat (2560) begin
				@(posedge ref_clk);
				#1;
				n0 += (led_drive[0] === 1'b1) ? 1 : 0;
				n1 += (led_drive[1] === 1'b1) ? 1 : 0;
			end
			check(16'(n0), highs[i]);
			check(16'(n1), 16'd0);
		end
		wr(MODE_CTRL2_ADDR, 8'h00);
	endtask

	// Channel 1 near full own duty under a half group duty, dim then blink;
	// five whole group periods give half on, less up to one own off step per own PWM period
	task automatic grp_scn();
		int n1;
		int win;
		wr(PWM_BASE_ADDR + 8'h01, 8'hFF);
		wr(GRP_DUTY_ADDR, 8'h80);
		wr(GRP_FREQ_ADDR, 8'h03);
		wr(LED_MODE0_ADDR, 8'h5D);
		for (int b = 0; b < 2; b++) begin
			wr(MODE_CTRL2_ADDR, (b == 1) ? 8'h20 : 8'h00);
			cycles(2048);
			win = (b == 1) ? 10240 : 5120;
			n1 = 0;
			repeat (win) begin
				@(posedge ref_clk);
				#1;
				n1 += (led_drive[1] === 1'b1) ? 1 : 0;
			end
			check(16'(n1 <= win / 2 && n1 >= win / 2 - win / 256), 16'h0001);
		end
		wr(MODE_CTRL2_ADDR, 8'h00);
	endtask

	task automatic filter_scn();
		@(posedge ref_clk);
		serial_in <= 2'b10;
		repeat (12) @(posedge ref_clk);
		serial_in <= 2'b11;
		cycles(3);
		check({14'h0000, serial_filt}, 16'h0003);
		@(posedge ref_clk);
		serial_in <= 2'b01;
		cycles(20);
		check({14'h0000, serial_filt}, 16'h0001);
		@(posedge ref_clk);
		serial_in <= 2'b11;
		cycles(20);
		check({14'h0000, serial_filt}, 16'h0003);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Clock, watchdog and main sequence
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (100000) @(posedge ref_clk);
		mismatches++;
		complete_run();
	end

	initial begin
		rst_b = 1'b0;
		bus_req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
		serial_in = 2'b11;
		connected = 16'hFFFF;
		hot_chan = 16'h0000;
		hot_global = 1'b0;
		mismatches = 0;
		samples_checked = 0;
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		cycles(1);
		reset_values();
		open_load_scn();
		global_ot_scn();
		chan_ot_scn();
		pwm_scn();
		grp_scn();
		filter_scn();
		complete_run();
	end
endmodule
